// ==== hw/rcf_stage_events.sv ====
// Stage status, blocking, event and history logic for the df/dt stages
`default_nettype none

module rcf_stage_events
	import rcf_pkg::*;
(
	// Clock, reset, enable
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             clk_en,
	// Processing cycle and pick-up
	input  wire logic             proc_tick,
	input  wire logic [7:0]       pickup,
	input  wire logic [127:0]     ratio_in,
	// Blocking matrix pins
	input  wire logic [7:0]       blk_pin,
	// Process values
	input  wire logic [15:0]      roc_in,
	input  wire logic [15:0]      frq_in,
	input  wire logic [31:0]      ts_in,
	input  wire logic [2:0]       sg_in,
	// Register port
	input  wire logic [7:0]       reg_addr,
	input  wire logic [31:0]      reg_wdata,
	input  wire logic             reg_wr,
	input  wire logic             reg_rd,
	output logic [31:0]           reg_rdata,
	// Stage outputs
	output logic [7:0]            stage_start,
	output logic [7:0]            stage_trip,
	output logic [7:0]            stage_blocked,
	output logic                  hmi_note,
	// Event stream
	output logic                  ev_valid,
	output rcf_event_s            ev_data
);

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Lowest set bit of the pending vector
	function automatic logic [5:0] rcf_first(input logic [63:0] v);
		logic [5:0] k;
		k = 6'h00;
		for (int j = 63; j >= 0; j--)
			if (v[j])
				k = 6'(j);
		return k;
	endfunction

	// One word of a history record
	function automatic logic [31:0] rcf_hword(input rcf_hist_s h, input logic [2:0] w);
		logic [31:0] r;
		r = 32'h0;
		unique case (w)
			3'h0: r = h.ev.ts;
			3'h1: r = {26'h0, h.ev.code};
			3'h2: r = {16'h0, h.pre_roc};
			3'h3: r = {16'h0, h.pre_frq};
			3'h4: r = {16'h0, h.ev.roc};
			3'h5: r = {16'h0, h.ev.frq};
			3'h6: r = {28'h0, h.sg};
			default: r = 32'h0;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Software registers
	// ----------------------------------------------------------------
	logic [5:0]       ctrl_r;
	logic [7:0]       force_r;
	logic [15:0]      rel_r;
	logic [6:0]       hsel_r;
	logic [21:0]      cfg_r [RCF_STAGES];
	logic [31:0]      rdata_r;

	wire [7:0] a_base = {reg_addr[7:3], 3'b000};
	wire [2:0] a_stg  = reg_addr[2:0];
	wire       wr_ok  = clk_en & reg_wr;
	wire [2:0] lnmode = ctrl_r[2:0];
	wire       frc_en = ctrl_r[RCF_FEN_BIT];
	wire       on_en  = ctrl_r[RCF_EON_BIT];
	wire       off_en = ctrl_r[RCF_EOFF_BIT];

	// Register writes
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ctrl_r  <= RCF_CTRL_RST;
			force_r <= 8'h00;
			rel_r   <= RCF_REL_RST;
			hsel_r  <= 7'h00;
			for (int s = 0; s < RCF_STAGES; s++)
				cfg_r[s] <= RCF_CFG_RST;
		end
		else if (wr_ok)
		begin
			if (reg_addr == RCF_OFF_CTRL)
				ctrl_r <= reg_wdata[5:0];
			if (reg_addr == RCF_OFF_FORCE)
				force_r <= reg_wdata[7:0];
			if (reg_addr == RCF_OFF_REL)
				rel_r <= reg_wdata[15:0];
			if (reg_addr == RCF_OFF_HSEL)
				hsel_r <= reg_wdata[6:0];
			if (a_base == RCF_OFF_CFG)
				cfg_r[a_stg] <= reg_wdata[21:0];
		end
	end

	// Node behaviour decode
	wire node_run = lnmode != RCF_LN_OFF;
	wire node_blk = (lnmode == RCF_LN_BLK) | (lnmode == RCF_LN_TBLK);

	// ----------------------------------------------------------------
	// Blocking input synchroniser and cycle sampling
	// ----------------------------------------------------------------
	logic [7:0]  blk_m_r;
	logic [7:0]  blk_s_r;
	logic [7:0]  blk_smp_r;
	logic [7:0]  pu_smp_r;
	logic        eval_r;
	logic [31:0] ts_lat_r;
	logic [15:0] roc_lat_r;
	logic [15:0] frq_lat_r;
	logic [3:0]  sg_lat_r;
	logic [15:0] pre_roc_r [RCF_PRE_TICKS];
	logic [15:0] pre_frq_r [RCF_PRE_TICKS];

	wire tick = clk_en & proc_tick;

	// Two flops ahead of any use
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			blk_m_r <= 8'h00;
			blk_s_r <= 8'h00;
		end
		else if (clk_en)
		begin
			blk_m_r <= blk_pin;
			blk_s_r <= blk_m_r;
		end
	end

	// Snapshot at the tick, evaluation one cycle later
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			blk_smp_r <= 8'h00;
			pu_smp_r  <= 8'h00;
			eval_r    <= 1'b0;
			ts_lat_r  <= 32'h0;
			roc_lat_r <= 16'h0;
			frq_lat_r <= 16'h0;
			sg_lat_r  <= 4'h1;
			for (int p = 0; p < RCF_PRE_TICKS; p++)
			begin
				pre_roc_r[p] <= 16'h0;
				pre_frq_r[p] <= 16'h0;
			end
		end
		else if (clk_en)
		begin
			eval_r <= proc_tick;
			if (proc_tick)
			begin
				blk_smp_r <= frc_en ? force_r : blk_s_r;
				pu_smp_r  <= pickup;
				ts_lat_r  <= ts_in;
				roc_lat_r <= roc_in;
				frq_lat_r <= frq_in;
				sg_lat_r  <= {1'b0, sg_in} + 4'h1;
				pre_roc_r[0] <= roc_lat_r; // Previous tick, so the last entry is four ticks back
				pre_frq_r[0] <= frq_lat_r;
				for (int p = 1; p < RCF_PRE_TICKS; p++)
				begin
					pre_roc_r[p] <= pre_roc_r[p-1];
					pre_frq_r[p] <= pre_frq_r[p-1];
				end
			end
		end
	end

	wire roc_neg = roc_lat_r[15];
	wire upd     = clk_en & eval_r;

	// ----------------------------------------------------------------
	// Per-stage definite-time state machines
	// ----------------------------------------------------------------
	logic [63:0]  ev_set;
	logic [7:0]   blk_rise;
	logic [15:0]  cond_v;
	logic [159:0] rem_v;
	logic [7:0]   pu_v;
	logic [7:0]   bk_v;

	for (genvar gi = 0; gi < RCF_STAGES; gi++)
	begin : g_stg
		rcf_cond_e            cond_r;
		rcf_cond_e            cond_nxt;
		logic [RCF_DLY_W-1:0] op_r;
		logic [RCF_DLY_W-1:0] op_nxt;
		logic [15:0]          rc_r;
		logic [15:0]          rc_nxt;

		wire [RCF_DLY_W-1:0] dly = cfg_r[gi][RCF_DLY_W-1:0];
		wire [1:0] dir    = cfg_r[gi][RCF_DIR_LSB +: 2];
		wire dir_ok = (dir == RCF_DIR_BOTH) | ((dir == RCF_DIR_RISE) & ~roc_neg)
			| ((dir == RCF_DIR_FALL) & roc_neg);
		wire pu   = pu_smp_r[gi] & cfg_r[gi][RCF_EN_BIT] & dir_ok & node_run;
		wire bk   = blk_smp_r[gi] | node_blk;
		wire act  = pu & ~bk;
		wire done = op_r >= dly;
		wire rdone = rc_r >= rel_r;

		// Next condition: blocking beats pick-up, timing only when free
		assign cond_nxt = !pu ? RCF_NORMAL : bk ? RCF_BLOCKED
			: done ? RCF_TRIP : RCF_START;
		// Operate timer holds while released, clears once reset time runs out
		assign op_nxt = act ? op_r + {{(RCF_DLY_W-1){1'b0}}, ~done}
			: rdone ? '0 : op_r;
		assign rc_nxt = act ? 16'h0 : rdone ? rc_r : rc_r + 16'h1;

		always_ff @(posedge core_clk)
		begin
			if (rst)
			begin
				cond_r <= RCF_NORMAL;
				op_r   <= '0;
				rc_r   <= 16'h0;
			end
			else if (upd)
			begin
				cond_r <= cond_nxt;
				op_r   <= op_nxt;
				rc_r   <= rc_nxt;
			end
		end

		wire s_now = (cond_r == RCF_START) | (cond_r == RCF_TRIP);
		wire s_new = (cond_nxt == RCF_START) | (cond_nxt == RCF_TRIP);
		wire t_now = cond_r == RCF_TRIP;
		wire t_new = cond_nxt == RCF_TRIP;
		wire b_now = cond_r == RCF_BLOCKED;
		wire b_new = cond_nxt == RCF_BLOCKED;
		wire [7:0] chg = {2'b00, b_now & ~b_new, b_new & ~b_now, t_now & ~t_new,
			t_new & ~t_now, s_now & ~s_new, s_new & ~s_now};
		wire [7:0] keep = {2'b00, {3{off_en, on_en}}};

		// Change edges filtered by the ON/OFF selection
		assign ev_set[gi*8 +: 8] = chg & keep & {8{upd}};
		assign blk_rise[gi]      = chg[4] & upd;
		assign stage_start[gi]   = s_now;
		assign stage_trip[gi]    = t_now;
		assign stage_blocked[gi] = b_now;
		assign cond_v[gi*2 +: 2] = cond_r;
		assign rem_v[gi*20 +: 20] = (cond_r == RCF_START)
			? 20'({1'b0, dly} - {1'b0, op_r}) : 20'h0;
		assign pu_v[gi] = pu;
		assign bk_v[gi] = bk;
	end

	// ----------------------------------------------------------------
	// Event serialiser and history
	// ----------------------------------------------------------------
	logic [63:0] pend_r;
	logic        ev_valid_r;
	rcf_event_s  ev_r;
	logic        note_r;
	logic [3:0]  hwp_r;
	logic [3:0]  hcnt_r;
	rcf_hist_s   hist_mem [RCF_HIST_DEPTH];

	wire [5:0]  sel      = rcf_first(pend_r);
	wire        emit     = |pend_r;
	wire [63:0] pend_nxt = (pend_r & ~(64'h1 << sel)) | ev_set; // set wins
	wire        h_wr     = emit & ((sel[2:0] == RCF_K_S_ON) | (sel[2:0] == RCF_K_T_ON));
	wire [3:0]  hwp_nxt  = (hwp_r == 4'(RCF_HIST_DEPTH - 1)) ? 4'h0 : hwp_r + 4'h1;
	wire rcf_event_s cur_ev = '{code: sel, ts: ts_lat_r, roc: roc_lat_r, frq: frq_lat_r};

	// One event per cycle, all events of a tick share its timestamp
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			pend_r     <= 64'h0;
			ev_valid_r <= 1'b0;
			ev_r       <= '0;
			note_r     <= 1'b0;
			hwp_r      <= 4'h0;
			hcnt_r     <= 4'h0;
		end
		else if (clk_en)
		begin
			pend_r     <= pend_nxt;
			ev_valid_r <= emit;
			note_r     <= |blk_rise;
			if (emit)
				ev_r <= cur_ev;
			if (h_wr)
			begin
				hwp_r  <= hwp_nxt;
				if (hcnt_r != 4'(RCF_HIST_DEPTH))
					hcnt_r <= hcnt_r + 4'h1;
			end
		end
	end

	// Record store, oldest entry overwritten
	always_ff @(posedge core_clk)
	begin
		if (clk_en & h_wr)
			hist_mem[hwp_r] <= '{ev: cur_ev, pre_roc: pre_roc_r[RCF_PRE_TICKS-1],
				pre_frq: pre_frq_r[RCF_PRE_TICKS-1], sg: sg_lat_r};
	end

	assign ev_valid = ev_valid_r;
	assign ev_data  = ev_r;
	assign hmi_note = note_r;

	// ----------------------------------------------------------------
	// Read decode
	// ----------------------------------------------------------------
	wire [15:0] roc_abs = roc_lat_r[15] ? 16'(-roc_lat_r) : roc_lat_r;
	wire [15:0] ratio   = ratio_in[a_stg*16 +: 16];
	wire [15:0] ratio_q = ratio - (ratio % 16'(RCF_QUANT));
	wire [19:0] rem_sel = rem_v[a_stg*20 +: 20];
	wire [3:0]  hrec    = (hsel_r[3:0] < 4'(RCF_HIST_DEPTH)) ? hsel_r[3:0] : 4'h0;
	wire [31:0] rd_mux  =
		(reg_addr == RCF_OFF_CTRL)  ? {26'h0, ctrl_r} :
		(reg_addr == RCF_OFF_FORCE) ? {24'h0, force_r} :
		(reg_addr == RCF_OFF_REL)   ? {16'h0, rel_r} :
		(reg_addr == RCF_OFF_HSEL)  ? {25'h0, hsel_r} :
		(reg_addr == RCF_OFF_HDAT)  ? rcf_hword(hist_mem[hrec], hsel_r[6:4]) :
		(reg_addr == RCF_OFF_MEAS)  ? {16'h0, roc_abs} :
		(reg_addr == RCF_OFF_BEHAV) ? {29'h0, lnmode} :
		(reg_addr == RCF_OFF_HPTR)  ? {24'h0, hcnt_r, hwp_r} :
		(a_base == RCF_OFF_CFG)     ? {10'h0, cfg_r[a_stg]} :
		(a_base == RCF_OFF_STAT)    ? {ratio_q, 14'h0, cond_v[a_stg*2 +: 2]} :
		(a_base == RCF_OFF_REM)     ? {{12{rem_sel[19]}}, rem_sel} : 32'h0;

	// Read data in the cycle after the strobe only
	always_ff @(posedge core_clk)
	begin
		if (rst)
			rdata_r <= 32'h0;
		else if (clk_en)
			rdata_r <= reg_rd ? rd_mux : 32'h0;
	end

	assign reg_rdata = rdata_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);

	// Stages that see pick-up and blocking together
	wire [7:0] pb_v = pu_v & bk_v;

	samp_tick_a: assert property (clk_en & $changed(stage_start) |-> $past(eval_r))
		else $error("start changed outside an evaluation");
	blk_pick_a: assert property (upd & |pb_v |=> (stage_blocked & ~stage_start & $past(pb_v)) == $past(pb_v))
		else $error("blocked pick-up did not give blocked");
	blk_clear_a: assert property (upd & |(stage_start & bk_v) |=> (stage_start & $past(bk_v)) == 8'h00)
		else $error("start survived blocking");
	trip_dly_a: assert property ($rose(stage_trip[1]) |-> g_stg[1].op_r >= cfg_r[1][RCF_DLY_W-1:0])
		else $error("trip before delay");
	ev_filt_a: assert property (ev_valid |-> (ev_data.code[0] ? off_en : on_en))
		else $error("filtered event emitted");
	ev_ts_a: assert property (clk_en & emit |=> ev_valid && ev_data.ts == $past(ts_lat_r))
		else $error("event timestamp wrong");
	hist_wrap_a: assert property (hwp_r < 4'(RCF_HIST_DEPTH))
		else $error("history pointer out of range");
	force_blk_a: assert property (tick & frc_en |=> blk_smp_r == $past(force_r))
		else $error("forced blocking not sampled");
	note_blk_a: assert property (upd & |blk_rise |=> hmi_note)
		else $error("no display note on blocking");

	trip_seen_c: cover property (stage_start[0] ##[1:40] stage_trip[0]);
	blocked_c: cover property ($rose(stage_blocked[0]));
	hist_full_c: cover property (hcnt_r == 4'(RCF_HIST_DEPTH));

endmodule

`default_nettype wire

// ==== hw/rcf_pkg.sv ====
// Constants and types for the rate-of-change-of-frequency stage logic
//
// Behaviour
// - Only definite-time delays for trip and reset
// - Sample blocking at start of each cycle
// - Unblocked pick-up asserts start, starts timing
// - Blocked pick-up asserts blocked, no timing
// - Blocking clears start, release timing follows
// - Blocking raises display note and event
// - Forcing switch drives blocking in test; forcing acts in any node mode here
// - Events on every change, ON/OFF filter
// - Six event codes for each stage
// - Events carry timestamp and process values
// - Twelve-deep circular history with pre-trigger values
// - History holds fault values and group index
// - Condition code normal/start/trip/blocked
// - Node behaviour code one to five
// - Measured rate exposed at 0.001 Hz/s
// - Ratio exposed in 0.005 per-unit steps
// - Expected operating time in 0.005 s steps
// - Signed remaining time counting down
// - Timestamps resolve one millisecond
// - Instant start and trip share timestamp
// - Direction setting rising, falling or both
`default_nettype none

package rcf_pkg;

	// ----------------------------------------------------------------
	// Sizes and time base
	// ----------------------------------------------------------------
	localparam int unsigned RCF_STAGES     = 8;
	localparam int unsigned RCF_HIST_DEPTH = 12;
	localparam int unsigned RCF_CYCLE_MS   = 5;
	localparam int unsigned RCF_PRE_MS     = 20;
	localparam int unsigned RCF_PRE_TICKS  = RCF_PRE_MS / RCF_CYCLE_MS;
	localparam int unsigned RCF_DLY_W      = 19;
	localparam int unsigned RCF_QUANT      = 5;

	// ----------------------------------------------------------------
	// Register offsets (word index on the plain port)
	// ----------------------------------------------------------------
	localparam logic [7:0] RCF_OFF_CTRL  = 8'h00;
	localparam logic [7:0] RCF_OFF_FORCE = 8'h01;
	localparam logic [7:0] RCF_OFF_REL   = 8'h02;
	localparam logic [7:0] RCF_OFF_HSEL  = 8'h03;
	localparam logic [7:0] RCF_OFF_HDAT  = 8'h04;
	localparam logic [7:0] RCF_OFF_MEAS  = 8'h05;
	localparam logic [7:0] RCF_OFF_BEHAV = 8'h06;
	localparam logic [7:0] RCF_OFF_HPTR  = 8'h07;
	localparam logic [7:0] RCF_OFF_CFG   = 8'h08;
	localparam logic [7:0] RCF_OFF_STAT  = 8'h10;
	localparam logic [7:0] RCF_OFF_REM   = 8'h18;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int unsigned RCF_DIR_LSB  = 19;
	localparam int unsigned RCF_EN_BIT   = 21;
	localparam int unsigned RCF_FEN_BIT  = 3;
	localparam int unsigned RCF_EON_BIT  = 4;
	localparam int unsigned RCF_EOFF_BIT = 5;
	localparam logic [5:0]  RCF_CTRL_RST = 6'h31;
	localparam logic [21:0] RCF_CFG_RST  = 22'h000014;
	localparam logic [15:0] RCF_REL_RST  = 16'h0000;
	localparam logic [1:0]  RCF_DIR_RISE = 2'h0;
	localparam logic [1:0]  RCF_DIR_FALL = 2'h1;
	localparam logic [1:0]  RCF_DIR_BOTH = 2'h2;

	// Event kinds, low three bits of an event code
	localparam logic [2:0] RCF_K_S_ON  = 3'h0;
	localparam logic [2:0] RCF_K_T_ON  = 3'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		RCF_NORMAL  = 2'b00,
		RCF_START   = 2'b01,
		RCF_TRIP    = 2'b10,
		RCF_BLOCKED = 2'b11
	} rcf_cond_e;

	typedef enum logic [2:0] {
		RCF_LN_ON    = 3'b001,
		RCF_LN_BLK   = 3'b010,
		RCF_LN_TEST  = 3'b011,
		RCF_LN_TBLK  = 3'b100,
		RCF_LN_OFF   = 3'b101
	} rcf_node_e;

	typedef struct packed {
		logic [5:0]  code;
		logic [31:0] ts;
		logic [15:0] roc;
		logic [15:0] frq;
	} rcf_event_s;

	typedef struct packed {
		rcf_event_s  ev;
		logic [15:0] pre_roc;
		logic [15:0] pre_frq;
		logic [3:0]  sg;
	} rcf_hist_s;

endpackage

`default_nettype wire

// ==== tb/rcf_far_model.sv ====
// Behavioural blocking matrix and relay event buffer facing the df/dt stage logic
`default_nettype none

module rcf_far_model
	import rcf_pkg::*;
(
	// Clock
	input  wire logic       core_clk,
	// Blocking requests from the bench
	input  wire logic [7:0] blk_req,
	output logic [7:0]      blk_pin,
	// Event stream from the block
	input  wire logic       ev_valid,
	input  wire rcf_event_s ev_data,
	output var int          ev_cnt
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [5:0]  ev_code [64];
	logic [31:0] ev_ts   [64];

	initial ev_cnt = 0;

	// Blocking levels change after an edge and stay for whole ticks
	always_ff @(posedge core_clk)
		blk_pin <= blk_req;

	// Event buffer keeps each code with its stamp
	always @(posedge core_clk)
		if (ev_valid === 1'b1 && ev_cnt < 64)
		begin
			ev_code[ev_cnt] = ev_data.code;
			ev_ts[ev_cnt] = ev_data.ts;
			ev_cnt++;
		end
endmodule

`default_nettype wire

// ==== tb/rcf_stage_block_event_logic_test.sv ====
// Self-checking bench for the df/dt stage status, blocking and event logic
`default_nettype none

module rcf_stage_block_event_logic_test
	import rcf_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;

	logic        core_clk, rst, clk_en, proc_tick, reg_wr, reg_rd, hmi_note, ev_valid;
	logic [7:0]  pickup, blk_req, blk_pin, reg_addr;
	logic [7:0]  stage_start, stage_trip, stage_blocked;
	logic [15:0] roc_in;
	logic [31:0] ts_in, reg_wdata, reg_rdata;
	rcf_event_s  ev_data;
	int          ev_cnt;
	int          eb = 0;
	int          note_count = 0;
	int          fail_count = 0;
	int          check_count = 0;

	rcf_stage_events rcf_stage_events_inst (
		.core_clk(core_clk), .rst(rst), .clk_en(clk_en), .proc_tick(proc_tick), .pickup(pickup),
		.ratio_in({8{16'h03E9}}), .blk_pin(blk_pin), .roc_in(roc_in), .frq_in(16'h1388),
		.ts_in(ts_in), .sg_in(3'h2), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .stage_start(stage_start), .stage_trip(stage_trip),
		.stage_blocked(stage_blocked), .hmi_note(hmi_note), .ev_valid(ev_valid), .ev_data(ev_data));

	rcf_far_model rcf_far_model_inst (
		.core_clk(core_clk), .blk_req(blk_req), .blk_pin(blk_pin), .ev_valid(ev_valid),
		.ev_data(ev_data), .ev_cnt(ev_cnt));

	// Clock and display-note pulse counter
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
		if (hmi_note === 1'b1)
			note_count++;

	// Compare, report and bus helpers
	task automatic chk(input logic [31:0] got, exp, input string m);
		check_count++;
		if (got !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string m);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(posedge core_clk);
		chk(reg_rdata, e, m);
	endtask
	task automatic tick(input int n);
		repeat (n)
		begin
			@(posedge core_clk);
			proc_tick <= 1'b1;
			ts_in <= ts_in + 32'h5;
			@(posedge core_clk);
			proc_tick <= 1'b0;
			repeat (72) @(posedge core_clk);
		end
	endtask
	task automatic blk(input logic [7:0] v);
		blk_req <= v;
		repeat (6) @(posedge core_clk);
	endtask
	task automatic outs(input logic [7:0] s, t, b);
		chk(stage_start, s, "start");
		chk(stage_trip, t, "trip");
		chk(stage_blocked, b, "blocked");
	endtask
	task automatic evs(input int n, input logic [5:0] c0, c1);
		chk(ev_cnt - eb, n, "event count");
		if (n > 0)
			chk(rcf_far_model_inst.ev_code[eb], c0, "code a");
		if (n > 1)
			chk(rcf_far_model_inst.ev_code[eb + 1], c1, "code b");
		eb = ev_cnt;
	endtask

	// Reset values, read-only and unmapped places
	task automatic s_regs();
		rchk(RCF_OFF_CTRL, 32'h31, "ctrl");
		rchk(RCF_OFF_CFG, 32'h14, "cfg");
		wr(RCF_OFF_BEHAV, 32'h7);
		rchk(RCF_OFF_BEHAV, 32'h1, "behaviour");
		rchk(8'h20, 32'h0, "unmapped");
		rchk(RCF_OFF_STAT, 32'h03E80000, "status");
	endtask

	// Instant stage: start and trip with one stamp
	task automatic s_instant();
		wr(RCF_OFF_CFG, 32'h00200000);
		pickup <= 8'h01;
		tick(1);
		outs(8'h01, 8'h01, 8'h00);
		chk(rcf_far_model_inst.ev_ts[eb], rcf_far_model_inst.ev_ts[eb + 1], "stamps");
		chk(rcf_far_model_inst.ev_ts[eb], 32'h5, "stamp value");
		evs(2, 6'h00, 6'h02);
		rchk(RCF_OFF_STAT, 32'h03E80002, "status trip");
		rchk(RCF_OFF_HPTR, 32'h22, "history pointer");
		pickup <= 8'h00;
		tick(1);
		outs(8'h00, 8'h00, 8'h00);
		evs(2, 6'h01, 6'h03);
	endtask

	// Definite delay of three ticks
	task automatic s_delay();
		wr(RCF_OFF_CFG + 8'h01, 32'h00200003);
		pickup <= 8'h02;
		tick(1);
		outs(8'h02, 8'h00, 8'h00);
		rchk(RCF_OFF_STAT + 8'h01, 32'h03E80001, "status start");
		rchk(RCF_OFF_REM + 8'h01, 32'h2, "remaining start");
		tick(1);
		outs(8'h02, 8'h00, 8'h00);
		tick(2);
		outs(8'h02, 8'h02, 8'h00);
		evs(2, 6'h08, 6'h0A);
		rchk(RCF_OFF_REM + 8'h01, 32'h0, "remaining");
		pickup <= 8'h00;
		tick(1);
		evs(2, 6'h09, 6'h0B);
	endtask

	// Blocking present before pick-up
	task automatic s_block_first();
		int n0;
		wr(RCF_OFF_CFG + 8'h02, 32'h00200005);
		blk(8'h04);
		n0 = note_count;
		pickup <= 8'h04;
		tick(1);
		outs(8'h00, 8'h00, 8'h04);
		chk(note_count - n0, 32'h1, "display note");
		evs(1, 6'h14, 6'h00);
		tick(6);
		outs(8'h00, 8'h00, 8'h04);
		blk(8'h00);
		tick(1);
		outs(8'h04, 8'h00, 8'h00);
		evs(2, 6'h10, 6'h15);
		pickup <= 8'h00;
		tick(1);
		evs(1, 6'h11, 6'h00);
	endtask

	// Blocking arriving while started
	task automatic s_block_during();
		wr(RCF_OFF_CFG + 8'h03, 32'h00200008);
		pickup <= 8'h08;
		tick(2);
		evs(1, 6'h18, 6'h00);
		blk(8'h08);
		tick(1);
		outs(8'h00, 8'h00, 8'h08);
		evs(2, 6'h19, 6'h1C);
		blk(8'h00);
		pickup <= 8'h00;
		tick(1);
		outs(8'h00, 8'h00, 8'h00);
		evs(1, 6'h1D, 6'h00);
	endtask

	// Software forcing of blocking
	task automatic s_force();
		wr(RCF_OFF_CFG + 8'h04, 32'h00200005);
		wr(RCF_OFF_CTRL, 32'h39);
		wr(RCF_OFF_FORCE, 32'h10);
		pickup <= 8'h10;
		tick(1);
		outs(8'h00, 8'h00, 8'h10);
		wr(RCF_OFF_FORCE, 32'h0);
		wr(RCF_OFF_CTRL, 32'h31);
		pickup <= 8'h00;
		tick(1);
		outs(8'h00, 8'h00, 8'h00);
		evs(2, 6'h24, 6'h25);
	endtask

	// Event edge selection
	task automatic s_filter();
		wr(RCF_OFF_CFG + 8'h05, 32'h00200000);
		wr(RCF_OFF_CTRL, 32'h11);
		pickup <= 8'h20;
		tick(1);
		evs(2, 6'h28, 6'h2A);
		pickup <= 8'h00;
		tick(1);
		evs(0, 6'h00, 6'h00);
		wr(RCF_OFF_CTRL, 32'h21);
		pickup <= 8'h20;
		tick(1);
		evs(0, 6'h00, 6'h00);
		pickup <= 8'h00;
		tick(1);
		evs(2, 6'h29, 6'h2B);
		wr(RCF_OFF_CTRL, 32'h31);
	endtask

	// Node modes and trip direction
	task automatic s_modes();
		logic [1:0] cond [5] = '{2'h1, 2'h3, 2'h1, 2'h3, 2'h0};
		wr(RCF_OFF_CFG + 8'h06, 32'h00200010);
		for (int m = 1; m <= 5; m++)
		begin
			wr(RCF_OFF_CTRL, 32'h30 | m);
			rchk(RCF_OFF_BEHAV, m, "behaviour");
			pickup <= 8'h40;
			tick(1);
			rchk(RCF_OFF_STAT + 8'h06, {16'h03E8, 14'h0, cond[m - 1]}, "mode status");
			pickup <= 8'h00;
			tick(1);
		end
		wr(RCF_OFF_CTRL, 32'h31);
		roc_in <= 16'hFF00;
		for (int d = 0; d < 3; d++)
		begin
			wr(RCF_OFF_CFG + 8'h07, 32'h00200010 | (d << 19));
			pickup <= 8'h80;
			tick(1);
			chk(stage_start, (d != 0) ? 8'h80 : 8'h00, "direction");
			pickup <= 8'h00;
			tick(1);
		end
		rchk(RCF_OFF_MEAS, 32'h0100, "measured rate");
		roc_in <= 16'h0100;
		eb = ev_cnt;
	endtask

	// Clock enable low: a tick with pick-up leaves no trace
	task automatic s_freeze();
		clk_en <= 1'b0;
		pickup <= 8'h01;
		tick(1);
		clk_en <= 1'b1;
		pickup <= 8'h00;
		outs(8'h00, 8'h00, 8'h00);
		evs(0, 6'h00, 6'h00);
	endtask

	// History depth, wrap, group word and values four ticks back
	task automatic s_history();
		wr(RCF_OFF_HSEL, 32'h60);
		rchk(RCF_OFF_HDAT, 32'h3, "group");
		rchk(RCF_OFF_HPTR, 32'hC0, "record count");
		roc_in <= 16'h0200;
		tick(1);
		roc_in <= 16'h0100;
		tick(3);
		pickup <= 8'h01;
		tick(1);
		pickup <= 8'h00;
		wr(RCF_OFF_HSEL, 32'h20);
		rchk(RCF_OFF_HDAT, 32'h0200, "pre-trigger rate");
		wr(RCF_OFF_HSEL, 32'h40);
		rchk(RCF_OFF_HDAT, 32'h0100, "fault rate");
		rchk(RCF_OFF_HPTR, 32'hC2, "record wrap");
	endtask

	// Watchdog
	initial
	begin
		repeat (100000) @(posedge core_clk);
		fail_count++;
		results();
	end

	// Main sequence
	initial
	begin
		rst = 1'b1;
		clk_en = 1'b1;
		proc_tick = 1'b0;
		pickup = 8'h00;
		blk_req = 8'h00;
		roc_in = 16'h0100;
		ts_in = 32'h0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		s_regs();
		s_instant();
		s_delay();
		s_block_first();
		s_block_during();
		s_force();
		s_filter();
		s_modes();
		s_freeze();
		s_history();
		results();
	end
endmodule

`default_nettype wire
